//--- common/twrs_if.sv
`timescale 1ns/1ns
interface twrs_if;
   logic scl;
   logic sda_host_out;
   logic sda_host_oe;
   logic sda_dev_out;
   logic sda_dev_oe;
   logic sda;
   // open-drain wire with pull-up: low whenever an enabled driver drives low
   assign sda = !((sda_host_oe && !sda_host_out) || (sda_dev_oe && !sda_dev_out));
   modport host (output scl, output sda_host_out, output sda_host_oe, input sda);
   modport dev (input scl, input sda, output sda_dev_out, output sda_dev_oe);
endinterface

//--- common/twrs_pkg.sv
package twrs_pkg;
   typedef logic [15:0] twrs_word_t;
   typedef logic [7:0] twrs_byte_t;
   typedef enum logic [2:0] {TD_IDLE, TD_ADDR, TD_RX, TD_ACK, TD_TX, TD_RACK, TD_IGNORE} twrs_dev_st_e;
   typedef enum logic {TH_IDLE, TH_RUN} twrs_host_st_e;
endpackage

//--- common/twrs_regs.svh
`ifndef TWRS_REGS_SVH
`define TWRS_REGS_SVH
// write-direction address bytes chosen by the address select strap
`define TWRS_WR_ADDR_LO 8'h90
`define TWRS_WR_ADDR_HI 8'hba
`define TWRS_DIR_BIT 0
`define TWRS_LAST_BIT 3'h7
`define TWRS_ACK_SLOT 4'h8
`define TWRS_FIRST_DATA 2'h2
`define TWRS_LAST_MSG 2'h3
`define TWRS_ADDR_STEP 16'h0001
`define TWRS_LINE_HIGH 1'b1
// link timing
`define TWRS_CLK_HZ 50000000
`define TWRS_SCL_HZ 400000
`define TWRS_QTRS_PER_BIT 4
// host item sequence
`define TWRS_SEQ_START 4'h0
`define TWRS_SEQ_DEV 4'h1
`define TWRS_SEQ_AHI 4'h2
`define TWRS_SEQ_ALO 4'h3
`define TWRS_SEQ_DHI 4'h4
`define TWRS_SEQ_DLO 4'h5
`define TWRS_SEQ_WSTOP 4'h6
`define TWRS_SEQ_RESTART 4'h4
`define TWRS_SEQ_RHI 4'h6
`define TWRS_SEQ_RLO 4'h7
`define TWRS_SEQ_RSTOP 4'h8
`endif

//--- hdl/twrs_master.sv
`timescale 1ns/1ns
`include "twrs_regs.svh"
module twrs_master #(
   parameter int CLK_HZ = `TWRS_CLK_HZ,
   parameter int SCL_HZ = `TWRS_SCL_HZ
) (
   // clock and reset
   input wire logic CLK,
   input wire logic SRST,
   input wire logic CE,
   // two-wire link
   twrs_if.host LINK,
   // request
   input wire logic GO,
   input wire logic READ,
   input wire logic ADDR_SEL,
   input wire twrs_pkg::twrs_word_t REG_ADDR,
   input wire twrs_pkg::twrs_word_t WR_DATA,
   // answer
   output logic READY,
   output logic DONE,
   output logic NACK,
   output twrs_pkg::twrs_word_t RD_DATA
);
   import twrs_pkg::*;

   // quarter bit period rounds up, so the clock never exceeds SCL_HZ
   localparam int QDIV = `TWRS_QTRS_PER_BIT * SCL_HZ;
   localparam int QTR = (CLK_HZ + QDIV - 1) / QDIV;
   localparam logic [7:0] QTR_LAST = 8'(QTR - 1);

   logic sda_m_ff;
   logic sda_s_ff;
   twrs_host_st_e st_ff, nxt_st;
   logic [7:0] div_ff, nxt_div;
   logic [1:0] q_ff, nxt_q;
   logic [3:0] bcnt_ff, nxt_bcnt;
   logic [3:0] seq_ff, nxt_seq;
   twrs_byte_t sh_ff, nxt_sh;
   logic scl_ff, nxt_scl;
   logic oe_ff, nxt_oe;
   logic rd_ff, nxt_rd;
   logic sel_ff, nxt_sel;
   twrs_word_t radr_ff, nxt_radr;
   twrs_word_t wdat_ff, nxt_wdat;
   twrs_byte_t rdhi_ff, nxt_rdhi;
   twrs_word_t rdata_ff, nxt_rdata;
   logic nack_ff, nxt_nack;
   logic done_ff, nxt_done;
   logic ready_ff, nxt_ready;

   wire tick = (st_ff == TH_RUN) && (div_ff == QTR_LAST);
   wire [3:0] stop_idx = rd_ff ? `TWRS_SEQ_RSTOP : `TWRS_SEQ_WSTOP;
   wire is_start = (seq_ff == `TWRS_SEQ_START) || (rd_ff && seq_ff == `TWRS_SEQ_RESTART);
   wire is_stop = (seq_ff == stop_idx);
   wire is_rx = rd_ff && (seq_ff == `TWRS_SEQ_RHI || seq_ff == `TWRS_SEQ_RLO);
   wire ack_slot = (bcnt_ff == `TWRS_ACK_SLOT);
   wire twrs_byte_t dev_wr = sel_ff ? `TWRS_WR_ADDR_HI : `TWRS_WR_ADDR_LO;
   wire twrs_byte_t tx_byte = (seq_ff == `TWRS_SEQ_DEV) ? dev_wr :
      (seq_ff == `TWRS_SEQ_AHI) ? radr_ff[15:8] :
      (seq_ff == `TWRS_SEQ_ALO) ? radr_ff[7:0] :
      rd_ff ? {dev_wr[7:1], 1'b1} :
      (seq_ff == `TWRS_SEQ_DHI) ? wdat_ff[15:8] : wdat_ff[7:0];
   wire twrs_byte_t tx_cur = (bcnt_ff == 4'h0) ? tx_byte : sh_ff;
   // ack the high read byte, leave the line high after the last one [R14] [R16]
   wire drive_low = ack_slot ? (is_rx && seq_ff == `TWRS_SEQ_RHI) : (!is_rx && !tx_cur[7]);

   always_comb begin
      nxt_st = st_ff;
      nxt_div = (st_ff == TH_RUN && !tick) ? div_ff + 8'h01 : 8'h00;
      nxt_q = q_ff;
      nxt_bcnt = bcnt_ff;
      nxt_seq = seq_ff;
      nxt_sh = sh_ff;
      nxt_scl = scl_ff;
      nxt_oe = oe_ff;
      nxt_rd = rd_ff;
      nxt_sel = sel_ff;
      nxt_radr = radr_ff;
      nxt_wdat = wdat_ff;
      nxt_rdhi = rdhi_ff;
      nxt_rdata = rdata_ff;
      nxt_nack = nack_ff;
      nxt_done = 1'b0;
      nxt_ready = ready_ff;
      if (st_ff == TH_IDLE) begin
         if (GO) begin
            nxt_st = TH_RUN;
            nxt_rd = READ;
            nxt_sel = ADDR_SEL;
            nxt_radr = REG_ADDR;
            nxt_wdat = WR_DATA;
            nxt_seq = `TWRS_SEQ_START;
            nxt_q = '0;
            nxt_bcnt = '0;
            nxt_nack = 1'b0;
            nxt_ready = 1'b0;
         end
      end else if (tick) begin
         nxt_q = q_ff + 2'h1;
         case (q_ff)
            2'h0: begin
               nxt_scl = 1'b0;
               nxt_oe = is_start ? 1'b0 : (is_stop ? 1'b1 : drive_low);
            end
            2'h1: nxt_scl = 1'b1;
            2'h2: begin
               if (is_start) begin
                  nxt_oe = 1'b1; // [R3] [R4] [R5]
               end else if (is_stop) begin
                  nxt_oe = 1'b0; // [R3] [R15]
               end else if (!ack_slot) begin
                  nxt_sh = is_rx ? {sh_ff[6:0], sda_s_ff} : {tx_cur[6:0], 1'b0};
               end else if (!is_rx && sda_s_ff) begin
                  nxt_nack = 1'b1;
               end
            end
            default: begin
               if (is_stop) begin
                  nxt_st = TH_IDLE;
                  nxt_ready = 1'b1;
                  nxt_done = 1'b1;
               end else begin
                  nxt_scl = 1'b0;
                  if (is_start) begin
                     nxt_seq = seq_ff + 4'h1;
                     nxt_bcnt = '0;
                  end else if (!ack_slot) begin
                     nxt_bcnt = bcnt_ff + 4'h1;
                  end else begin
                     nxt_bcnt = '0;
                     nxt_seq = nack_ff ? stop_idx : seq_ff + 4'h1;
                     if (rd_ff && seq_ff == `TWRS_SEQ_RHI) begin
                        nxt_rdhi = sh_ff;
                     end
                     if (rd_ff && seq_ff == `TWRS_SEQ_RLO) begin
                        nxt_rdata = {rdhi_ff, sh_ff};
                     end
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         sda_m_ff <= `TWRS_LINE_HIGH;
         sda_s_ff <= `TWRS_LINE_HIGH;
         st_ff <= TH_IDLE;
         div_ff <= '0;
         q_ff <= '0;
         bcnt_ff <= '0;
         seq_ff <= '0;
         sh_ff <= '0;
         scl_ff <= `TWRS_LINE_HIGH;
         oe_ff <= 1'b0;
         rd_ff <= 1'b0;
         sel_ff <= 1'b0;
         radr_ff <= '0;
         wdat_ff <= '0;
         rdhi_ff <= '0;
         rdata_ff <= '0;
         nack_ff <= 1'b0;
         done_ff <= 1'b0;
         ready_ff <= `TWRS_LINE_HIGH;
      end else if (CE) begin
         sda_m_ff <= LINK.sda;
         sda_s_ff <= sda_m_ff;
         st_ff <= nxt_st;
         div_ff <= nxt_div;
         q_ff <= nxt_q;
         bcnt_ff <= nxt_bcnt;
         seq_ff <= nxt_seq;
         sh_ff <= nxt_sh;
         scl_ff <= nxt_scl;
         oe_ff <= nxt_oe;
         rd_ff <= nxt_rd;
         sel_ff <= nxt_sel;
         radr_ff <= nxt_radr;
         wdat_ff <= nxt_wdat;
         rdhi_ff <= nxt_rdhi;
         rdata_ff <= nxt_rdata;
         nack_ff <= nxt_nack;
         done_ff <= nxt_done;
         ready_ff <= nxt_ready;
      end
   end

   assign LINK.scl = scl_ff; // [R1] [R8]
   assign LINK.sda_host_out = 1'b0;
   assign LINK.sda_host_oe = oe_ff;
   assign READY = ready_ff;
   assign DONE = done_ff;
   assign NACK = nack_ff;
   assign RD_DATA = rdata_ff;
endmodule

//--- hdl/twrs_slave.sv
// Notes on behaviour
// R1: host alone drives the serial clock
// R2: both lines high means bus idle
// R3: only host makes start and stop
// R4: start: data falls, clock high; restart reception
// R5: repeated start begins new address phase
// R6: bytes are eight bits, MSB first
// R7: each byte gets one acknowledge slot
// R8: one bit per clock, change only low
// R9: first byte: address [7:1], direction [0]
// R10: write address 0x90 or 0xBA by strap
// R11: read address 0x91 or 0xBB by strap
// R12: sixteen-bit register address follows address byte
// R13: sender releases data in acknowledge slot
// R14: receiver pulls data low to acknowledge
// R15: stop: data rises, clock high; go idle
// R16: no-acknowledge ends read, device releases data
// R17: write: address then data, all acknowledged
// R18: read: address, restart, read address, data
// R19: address mismatch: release, wait next start
// R20: sample lines through synchronisers, detect there
`timescale 1ns/1ns
`include "twrs_regs.svh"
module twrs_slave (
   // clock and reset
   input wire logic CLK,
   input wire logic SRST,
   input wire logic CE,
   // two-wire link
   twrs_if.dev LINK,
   // address select strap pin
   input wire logic ADDRESS_SELECT_STRAP,
   // register side
   output twrs_pkg::twrs_word_t REG_ADDR,
   output twrs_pkg::twrs_word_t WR_DATA,
   output logic WR_STROBE,
   input wire twrs_pkg::twrs_word_t RD_DATA,
   output logic RD_TAKEN,
   // status
   output logic BUSY,
   output logic BUS_IDLE
);
   import twrs_pkg::*;

   // bit 0 clock, bit 1 data, bit 2 strap; stage 0 is read only by stage 1
   logic [2:0] s0_ff;
   logic [2:0] s1_ff;
   logic [2:0] s2_ff;
   twrs_dev_st_e st_ff, nxt_st;
   logic [2:0] cnt_ff, nxt_cnt;
   twrs_byte_t sh_ff, nxt_sh;
   logic oe_ff, nxt_oe;
   logic rd_dir_ff, nxt_rd_dir;
   logic load_ff, nxt_load;
   logic [1:0] bcnt_ff, nxt_bcnt;
   logic bsel_ff, nxt_bsel;
   twrs_byte_t ahi_ff, nxt_ahi;
   twrs_byte_t dhi_ff, nxt_dhi;
   twrs_word_t addr_ff, nxt_addr;
   twrs_word_t wdata_ff, nxt_wdata;
   twrs_word_t hold_ff, nxt_hold;
   logic wstb_ff, nxt_wstb;
   logic taken_ff, nxt_taken;
   logic busy_ff;
   logic idle_ff;

   wire scl_s = s1_ff[0];
   wire scl_p = s2_ff[0];
   wire sda_s = s1_ff[1];
   wire sda_p = s2_ff[1];
   wire strap_s = s1_ff[2];
   wire scl_rise = scl_s && !scl_p;
   wire scl_fall = !scl_s && scl_p;
   wire start_cond = scl_s && scl_p && sda_p && !sda_s; // [R4] [R20]
   wire stop_cond = scl_s && scl_p && !sda_p && sda_s; // [R15] [R20]
   wire twrs_byte_t rx_byte = {sh_ff[6:0], sda_s}; // [R6]
   wire byte_end = scl_rise && (cnt_ff == `TWRS_LAST_BIT);
   // read address differs only in the direction bit, so one compare serves both
   wire twrs_byte_t own_wr = strap_s ? `TWRS_WR_ADDR_HI : `TWRS_WR_ADDR_LO; // [R10]
   wire addr_hit = (rx_byte[7:1] == own_wr[7:1]); // [R9] [R11]
   wire twrs_byte_t tx_byte = bsel_ff ? hold_ff[7:0] : RD_DATA[15:8];
   wire ack_tx = (st_ff == TD_ACK) && oe_ff && rd_dir_ff;
   wire do_load = scl_fall && (ack_tx || ((st_ff == TD_TX) && load_ff));

   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_sh = sh_ff;
      nxt_oe = oe_ff;
      nxt_rd_dir = rd_dir_ff;
      nxt_load = load_ff;
      nxt_bcnt = bcnt_ff;
      nxt_bsel = bsel_ff;
      nxt_ahi = ahi_ff;
      nxt_dhi = dhi_ff;
      nxt_addr = addr_ff;
      nxt_wdata = wdata_ff;
      nxt_hold = hold_ff;
      nxt_wstb = 1'b0;
      nxt_taken = 1'b0;
      // address moves on only after the strobe so REG_ADDR is valid with it
      if (wstb_ff) begin
         nxt_addr = addr_ff + `TWRS_ADDR_STEP;
      end
      if (stop_cond) begin
         nxt_st = TD_IDLE; // [R3] [R15]
         nxt_oe = 1'b0;
      end else if (start_cond) begin
         nxt_st = TD_ADDR; // [R3] [R4] [R5]
         nxt_cnt = '0;
         nxt_bcnt = '0;
         nxt_bsel = 1'b0;
         nxt_load = 1'b0;
         nxt_oe = 1'b0;
      end else begin
         case (st_ff)
            TD_ADDR, TD_RX: begin
               // data sampled on the rising clock edge only [R8]
               if (scl_rise) begin
                  nxt_sh = rx_byte; // [R6]
                  nxt_cnt = cnt_ff + 3'h1;
               end
               if (byte_end) begin
                  nxt_st = TD_ACK; // [R7]
                  if (st_ff == TD_ADDR) begin
                     nxt_rd_dir = rx_byte[`TWRS_DIR_BIT]; // [R9]
                     if (!addr_hit) begin
                        nxt_st = TD_IGNORE; // [R19]
                     end
                  end else begin
                     case (bcnt_ff)
                        2'h0: nxt_ahi = rx_byte; // [R12]
                        2'h1: nxt_addr = {ahi_ff, rx_byte}; // [R12]
                        `TWRS_FIRST_DATA: nxt_dhi = rx_byte; // [R17]
                        default: begin
                           nxt_wdata = {dhi_ff, rx_byte}; // [R17]
                           nxt_wstb = 1'b1;
                        end
                     endcase
                     nxt_bcnt = (bcnt_ff == `TWRS_LAST_MSG) ? `TWRS_FIRST_DATA : bcnt_ff + 2'h1;
                  end
               end
            end
            TD_ACK: begin
               if (scl_fall) begin
                  if (!oe_ff) begin
                     nxt_oe = 1'b1; // [R14] [R17]
                  end else if (rd_dir_ff) begin
                     nxt_st = TD_TX; // [R18]
                  end else begin
                     nxt_oe = 1'b0;
                     nxt_st = TD_RX;
                  end
               end
            end
            TD_TX: begin
               if (scl_rise) begin
                  nxt_cnt = cnt_ff + 3'h1;
                  if (cnt_ff == `TWRS_LAST_BIT) begin
                     nxt_st = TD_RACK; // [R7]
                  end
               end else if (scl_fall && !load_ff) begin
                  nxt_oe = !sh_ff[7]; // [R6] [R8]
                  nxt_sh = {sh_ff[6:0], 1'b0};
               end
            end
            TD_RACK: begin
               if (scl_fall) begin
                  nxt_oe = 1'b0; // [R13]
               end else if (scl_rise) begin
                  if (sda_s) begin
                     nxt_st = TD_IGNORE; // [R16]
                  end else begin
                     nxt_st = TD_TX; // [R18]
                     nxt_load = 1'b1;
                  end
               end
            end
            default: begin
            end
         endcase
      end
      // read words are latched whole so both bytes come from one register value
      if (do_load) begin
         nxt_oe = !tx_byte[7]; // [R6] [R8]
         nxt_sh = {tx_byte[6:0], 1'b0};
         nxt_load = 1'b0;
         nxt_cnt = '0;
         nxt_bsel = !bsel_ff;
         if (!bsel_ff) begin
            nxt_hold = RD_DATA;
            nxt_taken = 1'b1;
         end else begin
            nxt_addr = addr_ff + `TWRS_ADDR_STEP;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         s0_ff <= '0;
         s1_ff <= '0;
         s2_ff <= '0;
         st_ff <= TD_IDLE;
         cnt_ff <= '0;
         sh_ff <= '0;
         oe_ff <= 1'b0;
         rd_dir_ff <= 1'b0;
         load_ff <= 1'b0;
         bcnt_ff <= '0;
         bsel_ff <= 1'b0;
         ahi_ff <= '0;
         dhi_ff <= '0;
         addr_ff <= '0;
         wdata_ff <= '0;
         hold_ff <= '0;
         wstb_ff <= 1'b0;
         taken_ff <= 1'b0;
         busy_ff <= 1'b0;
         idle_ff <= 1'b0;
      end else if (CE) begin
         s0_ff <= {ADDRESS_SELECT_STRAP, LINK.sda, LINK.scl}; // [R1] [R20]
         s1_ff <= s0_ff;
         s2_ff <= s1_ff;
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         sh_ff <= nxt_sh;
         oe_ff <= nxt_oe;
         rd_dir_ff <= nxt_rd_dir;
         load_ff <= nxt_load;
         bcnt_ff <= nxt_bcnt;
         bsel_ff <= nxt_bsel;
         ahi_ff <= nxt_ahi;
         dhi_ff <= nxt_dhi;
         addr_ff <= nxt_addr;
         wdata_ff <= nxt_wdata;
         hold_ff <= nxt_hold;
         wstb_ff <= nxt_wstb;
         taken_ff <= nxt_taken;
         busy_ff <= (nxt_st != TD_IDLE);
         idle_ff <= scl_s && sda_s; // [R2]
      end
   end

   // open drain: the device only ever pulls the line low
   assign LINK.sda_dev_out = 1'b0;
   assign LINK.sda_dev_oe = oe_ff;
   assign REG_ADDR = addr_ff;
   assign WR_DATA = wdata_ff;
   assign WR_STROBE = wstb_ff;
   assign RD_TAKEN = taken_ff;
   assign BUSY = busy_ff;
   assign BUS_IDLE = idle_ff;
endmodule

//--- test/tb.sv
`timescale 1ns/1ns
module tb;
   import twrs_pkg::*;
   logic clk, srst, ce, go, rd, sel, strap;
   logic wr_strobe, rd_taken, busy, bus_idle, ready, done, nack, busy2, wr_strobe2, a, bump_due;
   twrs_word_t req_addr, req_wdata, reg_addr, wr_data, rd_data, got_data, reg_addr2;
   twrs_word_t last_wr_addr, last_wr_data;
   twrs_byte_t dev_byte;
   logic ack_bit;
   int n_mismatch = 0;
   int checked = 0;
   int n_wr = 0;
   int n_rd = 0;
   int n_wr2 = 0;
   int bitn = 99;

   twrs_if link ();
   twrs_if link2 ();
   twrs_slave twrs_slave_inst (.CLK(clk), .SRST(srst), .CE(ce), .LINK(link.dev),
      .ADDRESS_SELECT_STRAP(strap), .REG_ADDR(reg_addr), .WR_DATA(wr_data),
      .WR_STROBE(wr_strobe), .RD_DATA(rd_data), .RD_TAKEN(rd_taken), .BUSY(busy),
      .BUS_IDLE(bus_idle));
   twrs_master #(.SCL_HZ(2000000)) twrs_master_inst (.CLK(clk), .SRST(srst), .CE(ce),
      .LINK(link.host), .GO(go), .READ(rd), .ADDR_SEL(sel), .REG_ADDR(req_addr),
      .WR_DATA(req_wdata), .READY(ready), .DONE(done), .NACK(nack), .RD_DATA(got_data));
   // second slave faces the bench's own bit driver for misbehaving host traffic
   twrs_slave twrs_slave_inst2 (.CLK(clk), .SRST(srst), .CE(1'b1), .LINK(link2.dev),
      .ADDRESS_SELECT_STRAP(1'b0), .REG_ADDR(reg_addr2), .WR_DATA(), .WR_STROBE(wr_strobe2),
      .RD_DATA(16'h0000), .RD_TAKEN(), .BUSY(busy2), .BUS_IDLE());
   twrs_link_properties twrs_link_properties_inst (.CLK(clk), .SRST(srst), .scl(link.scl),
      .sda(link.sda), .sda_host_oe(link.sda_host_oe), .sda_dev_oe(link.sda_dev_oe),
      .sda_dev_out(link.sda_dev_out));

   // register file stand-in: value depends on the addressed word
   assign rd_data = reg_addr ^ 16'h5a3c;

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task end_sim;
      if (n_mismatch == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      if (bump_due === 1'b1) check("address step", reg_addr, last_wr_addr + 16'h0001);
      bump_due = (wr_strobe === 1'b1);
      if (wr_strobe === 1'b1) begin
         n_wr++;
         last_wr_addr = reg_addr;
         last_wr_data = wr_data;
      end
      if (rd_taken === 1'b1) n_rd++;
      if (wr_strobe2 === 1'b1) n_wr2++;
   end

   // wire watch: first byte and its acknowledge after each start
   always @(negedge link.sda) if (link.scl === 1'b1) bitn = 0;
   always @(posedge link.scl) begin
      if (bitn < 8) dev_byte = {dev_byte[6:0], link.sda};
      else if (bitn == 8) ack_bit = link.sda;
      if (bitn < 9) bitn++;
   end

   task xfer(input logic r, input logic s, input twrs_word_t addr, input twrs_word_t wd);
      int t;
      t = 0;
      while (ready !== 1'b1 && t < 100) begin
         @(posedge clk);
         t++;
      end
      // a host that never frees up is a failure, not a silent skip
      if (ready !== 1'b1) n_mismatch++;
      go <= 1'b1;
      rd <= r;
      sel <= s;
      req_addr <= addr;
      req_wdata <= wd;
      @(posedge clk);
      go <= 1'b0;
      t = 0;
      while (done !== 1'b1 && t < 5000) begin
         @(posedge clk);
         t++;
      end
      if (done !== 1'b1) n_mismatch++;
      repeat (16) @(posedge clk);
   endtask

   // one quarter of a 160 ns bench link clock
   task bb_q(input logic c, input logic oe);
      link2.scl <= c;
      link2.sda_host_oe <= oe;
      repeat (2) @(posedge clk);
   endtask

   task bb_bit(input logic b, output logic seen);
      bb_q(1'b0, link2.sda_host_oe);
      bb_q(1'b0, !b);
      bb_q(1'b1, !b);
      seen = link2.sda;
      bb_q(1'b1, !b);
   endtask

   task bb_start;
      bb_q(1'b0, link2.sda_host_oe);
      bb_q(1'b0, 1'b0);
      bb_q(1'b1, 1'b0);
      bb_q(1'b1, 1'b1);
   endtask

   task bb_byte(input twrs_byte_t b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bb_bit(b[i], s);
      bb_bit(1'b1, ack);
   endtask

   initial begin
      srst = 1'b1;
      ce = 1'b1;
      go = 1'b0;
      rd = 1'b0;
      sel = 1'b0;
      strap = 1'b0;
      req_addr = 16'h0000;
      req_wdata = 16'h0000;
      link2.scl = 1'b1;
      link2.sda_host_oe = 1'b0;
      link2.sda_host_out = 1'b0;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      repeat (8) @(posedge clk);
      check("idle at start", {15'h0, bus_idle}, 16'h0001);
      for (int s = 0; s < 2; s++) begin
         strap <= s[0];
         repeat (4) @(posedge clk);
         xfer(1'b0, s[0], 16'h1234 + 16'(s), 16'ha5c3 ^ 16'(s));
         check("write strobes", 16'(n_wr), 16'(s + 1));
         check("write address", last_wr_addr, 16'h1234 + 16'(s));
         check("write data", last_wr_data, 16'ha5c3 ^ 16'(s));
         check("write address byte", {8'h00, dev_byte}, s ? 16'h00ba : 16'h0090);
         check("address ack", {15'h0, ack_bit}, 16'h0000);
         check("busy after stop", {15'h0, busy}, 16'h0000);
         check("idle after stop", {15'h0, bus_idle}, 16'h0001);
         xfer(1'b1, s[0], 16'h00ff + 16'(s), 16'h0000);
         check("read data", got_data, (16'h00ff + 16'(s)) ^ 16'h5a3c);
         check("read address byte", {8'h00, dev_byte}, s ? 16'h00bb : 16'h0091);
         check("read words taken", 16'(n_rd), 16'(s + 1));
         check("read host bytes acked", {15'h0, nack}, 16'h0000);
         check("busy after read", {15'h0, busy}, 16'h0000);
         xfer(1'b0, !s[0], 16'h4321, 16'h0f0f);
         check("foreign address nack", {15'h0, nack}, 16'h0001);
         check("foreign ack bit", {15'h0, ack_bit}, 16'h0001);
         check("foreign write ignored", 16'(n_wr), 16'(s + 1));
      end
      bb_start;
      bb_byte(8'h90, a);
      check("raw address ack", {15'h0, a}, 16'h0000);
      bb_byte(8'h00, a);
      bb_byte(8'h20, a);
      bb_byte(8'h12, a);
      check("raw data ack", {15'h0, a}, 16'h0000);
      bb_start;
      bb_byte(8'hba, a);
      check("restart foreign nack", {15'h0, a}, 16'h0001);
      bb_byte(8'h55, a);
      check("ignored byte nack", {15'h0, a}, 16'h0001);
      bb_start;
      bb_byte(8'h90, a);
      check("restart address ack", {15'h0, a}, 16'h0000);
      bb_bit(1'b1, a);
      bb_bit(1'b0, a);
      bb_bit(1'b0, a);
      bb_q(1'b0, 1'b1);
      bb_q(1'b1, 1'b1);
      bb_q(1'b1, 1'b0);
      repeat (8) @(posedge clk);
      check("stop mid byte idles", {15'h0, busy2}, 16'h0000);
      check("odd byte not written", 16'(n_wr2), 16'h0000);
      check("raw register address", reg_addr2, 16'h0020);
      // two words in one frame: the data byte pair wraps and the address steps per word
      bb_start;
      bb_byte(8'h90, a);
      bb_byte(8'h00, a);
      bb_byte(8'h30, a);
      bb_byte(8'hab, a);
      bb_byte(8'hcd, a);
      bb_byte(8'h12, a);
      bb_byte(8'h34, a);
      check("second word ack", {15'h0, a}, 16'h0000);
      bb_q(1'b0, 1'b1);
      bb_q(1'b1, 1'b1);
      bb_q(1'b1, 1'b0);
      repeat (8) @(posedge clk);
      check("sequential words written", 16'(n_wr2), 16'h0002);
      check("sequential address step", reg_addr2, 16'h0032);
      check("idle after sequential stop", {15'h0, busy2}, 16'h0000);
      end_sim;
   end

   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      end_sim;
   end
endmodule

//--- test/twrs_link_properties.sv
`timescale 1ns/1ns
module twrs_link_properties (
   // clock and reset
   input wire logic CLK,
   input wire logic SRST,
   // link wires
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_host_oe,
   input wire logic sda_dev_oe,
   input wire logic sda_dev_out
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SRST);

   // five cycles stays inside the 7-cycle quarter after each clock rise in the bench, before a start or stop moves data
   chk_data_stable: assert property ($rose(scl) |=> $stable(sda) [*5])
      else $error("data line moved while serial clock high");
   chk_dev_change_low: assert property ($changed(sda_dev_oe) |-> !scl && !$past(scl) && !$past(scl, 2))
      else $error("device changed data outside the low phase");
   chk_sender_release: assert property (scl && sda_dev_oe |-> !sda_host_oe)
      else $error("host still driving while device owns the bit");
   chk_ack_pulls_low: assert property (sda_dev_oe |-> !sda_dev_out && !sda)
      else $error("device drive did not pull the line low");
   chk_start_frame: assert property (scl && $past(scl) && $fell(sda) |-> scl [*5])
      else $error("start condition not held with clock high");
   chk_stop_release: assert property (scl && $past(scl) && $rose(sda) |=> !sda_dev_oe [*8])
      else $error("device drives after stop");
   chk_idle_after_stop: assert property (scl && $past(scl) && $rose(sda) |-> (scl && sda) [*8])
      else $error("bus not idle after stop");
   chk_scl_low_width: assert property ($fell(scl) |-> !scl [*6])
      else $error("serial clock low phase too short");
endmodule
